// ===== bench/fb_node_model.sv
`timescale 1ns/1ps
`default_nettype none
module fb_node_model #(
   parameter logic [7:0] NOM = 8'h7f
) (
   input wire logic clk_in,
   input wire logic [7:0] code_in,
   input wire logic drive_in,
   output logic [7:0] node_out
);
   // Node rests at the converter's own level unless the buffer drives it
   always_ff @(posedge clk_in) begin
      node_out <= drive_in ? code_in : NOM;
   end
endmodule // fb_node_model
`default_nettype wire

// ===== bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench import margin_dac_pkg::*;;
   logic clk_in = 0;
   logic rst_b_in = 0;
   logic wr_s = 0;
   logic rd_s = 0;
   logic nv_load = 0;
   logic margin_up_request = 0;
   logic margin_down_request = 0;
   logic [7:0] addr = 0, wdata = 0, nv_lo = 0, nv_hi = 0, rdata, node, r, c;
   logic [2:0] nv_ch = 0;
   logic [47:0] code_o;
   logic [11:0] rng_o;
   logic [5:0] pwr_o, drv_o;
   logic [7:0] corner [6] = '{8'h3f, 8'h40, 8'hc0, 8'hc1, 8'h00, 8'hff};
   int err_total = 0;
   int checks_done = 0;
   int seed = 32'h91e6;
   int ch;

   margin_dac_ctrl i_dut (.clk_in(clk_in), .rst_b_in(rst_b_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
      .nv_load_in(nv_load), .nv_ch_in(nv_ch), .nv_lower_in(nv_lo), .nv_upper_in(nv_hi),
      .margin_up_request_in(margin_up_request), .margin_down_request_in(margin_down_request),
      .dac_code_out(code_o), .range_sel_out(rng_o), .buf_power_out(pwr_o),
      .buf_drive_out(drv_o));
   fb_node_model i_node (.clk_in(clk_in), .code_in(code_o[7:0]), .drive_in(drv_o[0]),
      .node_out(node));

   initial begin
      forever #50 clk_in = ~clk_in;
   end

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      wdata <= d;
      wr_s <= 1'b1;
      @(posedge clk_in);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk_in);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge clk_in);
      rd_s <= 1'b0;
      @(posedge clk_in);
      #1 d = rdata;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask
   function automatic logic [7:0] clampf(input logic [7:0] v, lo, hi);
      return (v < lo) ? lo : ((v > hi) ? hi : v);
   endfunction
   task automatic all_codes(input logic [7:0] exp);
      for (int n = 0; n < 6; n++) chk(code_o[8*n+:8], exp);
   endtask
   task automatic end_of_test;
      if (err_total == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      #(100 * 5000);
      err_total++;
      end_of_test;
   end

   initial begin
      repeat (8) @(posedge clk_in);
      all_codes(CODE_RST);
      rst_b_in <= 1'b1;
      settle(1);
      // Limits start inverted, so the clamp pulls every code to the lower limit
      all_codes(clampf(CODE_RST, LOWER_RST, UPPER_RST));
      chk({2'b0, pwr_o}, 8'h00);
      chk({2'b0, drv_o}, 8'h00);
      for (int n = 0; n < 6; n++) begin
         @(posedge clk_in);
         nv_load <= 1'b1;
         nv_ch <= 3'(n);
         nv_lo <= 8'h40;
         nv_hi <= 8'hc0;
      end
      @(posedge clk_in);
      nv_load <= 1'b0;
      for (int n = 0; n < 6; n++) begin
         rd(LOWER_BASE + 8'(n), r);
         chk(r, 8'h40);
         rd(UPPER_BASE + 8'(n), r);
         chk(r, 8'hc0);
      end
      for (int m = 0; m < 4; m++) wr(RANGE_BASE + 8'(m), 8'(m));
      settle(2);
      for (int m = 0; m < 4; m++) chk({6'b0, rng_o[2*m+:2]}, 8'(m));
      // Corners first, then random codes on random channels
      for (int i = 0; i < 16; i++) begin
         ch = (i < 6) ? i : {$random(seed)} % 6;
         c = (i < 6) ? corner[i] : 8'($random(seed));
         wr(CODE_BASE + 8'(ch), c);
         settle(3);
         chk(code_o[8*ch+:8], clampf(c, 8'h40, 8'hc0));
         rd(APPLIED_BASE + 8'(ch), r);
         chk(r, clampf(c, 8'h40, 8'hc0));
         rd(CODE_BASE + 8'(ch), r);
         chk(r, c);
      end
      // Preset code to the node level before enabling
      for (int n = 0; n < 6; n++) wr(CODE_BASE + 8'(n), 8'h7f);
      wr(ENABLE_OFS, 8'h3f);
      settle(3);
      chk({2'b0, pwr_o}, 8'h3f);
      chk({2'b0, drv_o}, 8'h00);
      settle(17);
      chk({2'b0, drv_o}, 8'h00);
      settle(6);
      chk({2'b0, drv_o}, 8'h3f);
      chk(node, 8'h7f);
      rd(ENABLE_OFS, r);
      chk(r, 8'h3f);
      rd(HIZ_OFS, r);
      chk(r, 8'h00);
      @(posedge clk_in);
      margin_up_request <= 1'b1;
      settle(5);
      all_codes(8'h40);
      chk(node, 8'h40);
      @(posedge clk_in);
      margin_down_request <= 1'b1;
      settle(5);
      chk(code_o[7:0], 8'h40);
      @(posedge clk_in);
      margin_up_request <= 1'b0;
      settle(5);
      all_codes(8'hc0);
      chk(node, 8'hc0);
      @(posedge clk_in);
      margin_down_request <= 1'b0;
      settle(5);
      all_codes(8'h7f);
      wr(LOWER_BASE, 8'hd0);
      settle(3);
      chk({7'b0, drv_o[0]}, 8'h00);
      chk({7'b0, drv_o[1]}, 8'h01);
      rd(HIZ_OFS, r);
      chk(r, 8'h01);
      // Widest limits on channel 1 expose both ends of the code span
      wr(LOWER_BASE + 8'h01, 8'h00);
      wr(UPPER_BASE + 8'h01, 8'hff);
      wr(CODE_BASE + 8'h01, 8'hff);
      settle(3);
      chk(code_o[15:8], 8'hff);
      wr(CODE_BASE + 8'h01, 8'h00);
      settle(3);
      chk(code_o[15:8], 8'h00);
      wr(ENABLE_OFS, 8'h00);
      settle(3);
      chk({2'b0, pwr_o}, 8'h00);
      chk({2'b0, drv_o}, 8'h00);
      rd(8'h30, r);
      chk(r, 8'h00);
      end_of_test;
   end
endmodule // testbench
`default_nettype wire

// ===== rtl/margin_dac_ctrl.sv
// Contract
// RULE1: Six channels, each with code, limits, buffer
// RULE2: Applied code clamped between lower and upper
// RULE3: Inverted limits keep buffer high impedance
// RULE4: Margin-up request selects lower limit code
// RULE5: Margin-down request selects upper limit code
// RULE6: Four selectable midcode ranges per channel
// RULE7: Code is unsigned eight-bit, linear output
// RULE8: Span is +128 and -127 codes around midcode
// RULE9: Limits restored from nonvolatile load at start-up
// RULE10: Host disables, presets code, enables, then margins
// RULE11: Buffer tracks pin first, then drives DAC
// RULE12: Code writes apply at any time, clamped
// RULE13: No request drives clamped code; fast response
// RULE14: Outputs disabled after reset
`timescale 1ns/1ps
`default_nettype none
module margin_dac_ctrl import margin_dac_pkg::*; #(
   parameter int unsigned NUM_CH = CH_COUNT
) (
   input wire logic clk_in,
   input wire logic rst_b_in,
   input wire logic [ADDR_W-1:0] reg_addr_in,
   input wire logic [CODE_W-1:0] reg_wdata_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   output logic [CODE_W-1:0] reg_rdata_out,
   input wire logic nv_load_in,
   input wire logic [CH_SEL_W-1:0] nv_ch_in,
   input wire logic [CODE_W-1:0] nv_lower_in,
   input wire logic [CODE_W-1:0] nv_upper_in,
   input wire logic margin_up_request_in,
   input wire logic margin_down_request_in,
   output logic [NUM_CH*CODE_W-1:0] dac_code_out,
   output logic [NUM_CH*RANGE_W-1:0] range_sel_out,
   output logic [NUM_CH-1:0] buf_power_out,
   output logic [NUM_CH-1:0] buf_drive_out
);
   logic [CODE_W-1:0] code_q [NUM_CH];
   logic [CODE_W-1:0] code_d [NUM_CH];
   logic [CODE_W-1:0] lower_q [NUM_CH];
   logic [CODE_W-1:0] lower_d [NUM_CH];
   logic [CODE_W-1:0] upper_q [NUM_CH];
   logic [CODE_W-1:0] upper_d [NUM_CH];
   logic [RANGE_W-1:0] range_q [NUM_CH];
   logic [RANGE_W-1:0] range_d [NUM_CH];
   logic [CODE_W-1:0] applied_q [NUM_CH];
   logic [CODE_W-1:0] applied_d [NUM_CH];
   ch_state_e st_q [NUM_CH];
   ch_state_e st_d [NUM_CH];
   logic [TRACK_CNT_W-1:0] cnt_q [NUM_CH];
   logic [TRACK_CNT_W-1:0] cnt_d [NUM_CH];
   logic [NUM_CH-1:0] en_q;
   logic [NUM_CH-1:0] en_d;
   logic [NUM_CH-1:0] drive_q;
   logic [NUM_CH-1:0] drive_d;
   logic [NUM_CH-1:0] hiz;
   logic [CODE_W-1:0] rdata_q;
   logic [CODE_W-1:0] rdata_d;
   logic mup_meta_q;
   logic mup_q;
   logic mdn_meta_q;
   logic mdn_q;

   function automatic logic [CODE_W-1:0] clamp_code(input logic [CODE_W-1:0] c,
         input logic [CODE_W-1:0] lo, input logic [CODE_W-1:0] hi);
      if (c < lo) begin
         clamp_code = lo;
      end else if (c > hi) begin
         clamp_code = hi;
      end else begin
         clamp_code = c;
      end
   endfunction

   // Request pins come from outside; two flops before use
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         mup_meta_q <= 1'b0;
         mup_q <= 1'b0;
         mdn_meta_q <= 1'b0;
         mdn_q <= 1'b0;
      end else begin
         mup_meta_q <= margin_up_request_in;
         mup_q <= mup_meta_q;
         mdn_meta_q <= margin_down_request_in;
         mdn_q <= mdn_meta_q;
      end
   end

   always_comb begin
      en_d = en_q;
      rdata_d = rdata_q;
      if (reg_wr_in && reg_addr_in == ENABLE_OFS) begin
         en_d = reg_wdata_in[NUM_CH-1:0];
      end
      if (reg_rd_in) begin
         rdata_d = '0;
         if (reg_addr_in == ENABLE_OFS) begin
            rdata_d[NUM_CH-1:0] = en_q;
         end
         if (reg_addr_in == HIZ_OFS) begin
            rdata_d[NUM_CH-1:0] = hiz;
         end
      end
      for (int i = 0; i < NUM_CH; i++) begin // RULE1
         code_d[i] = code_q[i];
         lower_d[i] = lower_q[i];
         upper_d[i] = upper_q[i];
         range_d[i] = range_q[i];
         st_d[i] = st_q[i];
         cnt_d[i] = cnt_q[i];
         if (reg_wr_in) begin
            if (reg_addr_in == CODE_BASE + ADDR_W'(i)) begin
               code_d[i] = reg_wdata_in; // RULE12
            end
            if (reg_addr_in == LOWER_BASE + ADDR_W'(i)) begin
               lower_d[i] = reg_wdata_in;
            end
            if (reg_addr_in == UPPER_BASE + ADDR_W'(i)) begin
               upper_d[i] = reg_wdata_in;
            end
            if (reg_addr_in == RANGE_BASE + ADDR_W'(i)) begin
               range_d[i] = reg_wdata_in[RANGE_W-1:0]; // RULE6
            end
         end
         // Start-up load wins over a bus write in the same cycle
         if (nv_load_in && nv_ch_in == CH_SEL_W'(i)) begin
            lower_d[i] = nv_lower_in; // RULE9
            upper_d[i] = nv_upper_in; // RULE9
         end
         if (reg_rd_in) begin
            if (reg_addr_in == CODE_BASE + ADDR_W'(i)) begin
               rdata_d = code_q[i];
            end
            if (reg_addr_in == LOWER_BASE + ADDR_W'(i)) begin
               rdata_d = lower_q[i];
            end
            if (reg_addr_in == UPPER_BASE + ADDR_W'(i)) begin
               rdata_d = upper_q[i];
            end
            if (reg_addr_in == RANGE_BASE + ADDR_W'(i)) begin
               rdata_d = {{(CODE_W-RANGE_W){1'b0}}, range_q[i]};
            end
            if (reg_addr_in == APPLIED_BASE + ADDR_W'(i)) begin
               rdata_d = applied_q[i];
            end
         end
         // Up beats down if both are held; full 8-bit code passes through
         if (mup_q) begin
            applied_d[i] = lower_q[i]; // RULE4
         end else if (mdn_q) begin
            applied_d[i] = upper_q[i]; // RULE5
         end else begin
            applied_d[i] = clamp_code(code_q[i], lower_q[i], upper_q[i]); // RULE2 RULE7 RULE8 RULE13
         end
         case (st_q[i])
            CH_OFF: begin
               if (en_q[i]) begin
                  st_d[i] = CH_TRACK; // RULE11
                  cnt_d[i] = TRACK_CNT_W'(TRACK_CYCLES - 1);
               end
            end
            CH_TRACK: begin
               if (!en_q[i]) begin
                  st_d[i] = CH_OFF;
               end else if (cnt_q[i] == '0) begin
                  st_d[i] = CH_DRIVE; // RULE11
               end else begin
                  cnt_d[i] = cnt_q[i] - 1'b1;
               end
            end
            CH_DRIVE: begin
               if (!en_q[i]) begin
                  st_d[i] = CH_OFF;
               end
            end
            default: begin
               st_d[i] = CH_OFF;
            end
         endcase
         // Looks at next limits so an inversion cuts the stage at once
         drive_d[i] = (st_d[i] == CH_DRIVE) && !(lower_d[i] > upper_d[i]); // RULE3
         hiz[i] = lower_q[i] > upper_q[i];
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         en_q <= '0; // RULE14
         drive_q <= '0; // RULE14
         rdata_q <= '0;
         for (int i = 0; i < NUM_CH; i++) begin
            code_q[i] <= CODE_RST;
            lower_q[i] <= LOWER_RST;
            upper_q[i] <= UPPER_RST;
            range_q[i] <= RANGE_RST;
            applied_q[i] <= CODE_RST;
            st_q[i] <= CH_OFF;
            cnt_q[i] <= '0;
         end
      end else begin
         en_q <= en_d;
         drive_q <= drive_d;
         rdata_q <= rdata_d;
         for (int i = 0; i < NUM_CH; i++) begin
            code_q[i] <= code_d[i];
            lower_q[i] <= lower_d[i];
            upper_q[i] <= upper_d[i];
            range_q[i] <= range_d[i];
            applied_q[i] <= applied_d[i];
            st_q[i] <= st_d[i];
            cnt_q[i] <= cnt_d[i];
         end
      end
   end

   assign reg_rdata_out = rdata_q;
   assign buf_drive_out = drive_q;

   for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
      logic pwr_q;
      always_ff @(posedge clk_in or negedge rst_b_in) begin
         if (!rst_b_in) begin
            pwr_q <= 1'b0;
         end else begin
            pwr_q <= (st_d[g] != CH_OFF);
         end
      end
      assign buf_power_out[g] = pwr_q;
      assign dac_code_out[g*CODE_W +: CODE_W] = applied_q[g];
      assign range_sel_out[g*RANGE_W +: RANGE_W] = range_q[g];

      hiz_guard_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE3
         (lower_q[g] > upper_q[g]) |-> !drive_q[g])
         else $error("buffer driven with inverted limits");
      margin_up_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE4
         mup_q |=> applied_q[g] == $past(lower_q[g]))
         else $error("margin up did not select lower limit");
      margin_down_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE5
         (!mup_q && mdn_q) |=> applied_q[g] == $past(upper_q[g]))
         else $error("margin down did not select upper limit");
      clamp_code_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
         (!mup_q && !mdn_q && code_q[g] >= lower_q[g] && code_q[g] <= upper_q[g])
         |=> applied_q[g] == $past(code_q[g]))
         else $error("in-range code not applied");
      clamp_low_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE2
         (!mup_q && !mdn_q && code_q[g] < lower_q[g]) |=> applied_q[g] == $past(lower_q[g]))
         else $error("low code not clamped");
      track_first_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE11
         $rose(buf_power_out[g]) |-> !drive_q[g] ##1 !drive_q[g] [*8])
         else $error("output stage on without tracking");
      nv_restore_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE9
         (nv_load_in && nv_ch_in == CH_SEL_W'(g))
         |=> (lower_q[g] == $past(nv_lower_in) && upper_q[g] == $past(nv_upper_in)))
         else $error("limits not restored");
      margin_lat_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE13
         (margin_up_request_in [*3] ##0 $stable(lower_q[g])) |=> applied_q[g] == $past(lower_q[g]))
         else $error("margin up too slow");
      off_idle_a: assert property (@(posedge clk_in) disable iff (!rst_b_in) // RULE14
         !en_q[g] |=> !drive_q[g])
         else $error("disabled channel still drives");
   end
endmodule // margin_dac_ctrl
`default_nettype wire

// ===== shared/margin_dac_pkg.sv
package margin_dac_pkg;
   localparam int unsigned CODE_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned CH_COUNT = 6;
   localparam int unsigned RANGE_W = 2;
   localparam int unsigned CH_SEL_W = 3;
   // Midcode sits at 0x7f in every range; linear unsigned code
   localparam logic [CODE_W-1:0] MID_CODE = 8'h7f;
   // Range encodings: midcode at 0.6 V, 0.8 V, 1.0 V, 1.25 V
   localparam logic [RANGE_W-1:0] RANGE_0V60 = 2'h0;
   localparam logic [RANGE_W-1:0] RANGE_0V80 = 2'h1;
   localparam logic [RANGE_W-1:0] RANGE_1V00 = 2'h2;
   localparam logic [RANGE_W-1:0] RANGE_1V25 = 2'h3;
   // Register map
   localparam logic [ADDR_W-1:0] CODE_BASE = 8'h00;
   localparam logic [ADDR_W-1:0] LOWER_BASE = 8'h08;
   localparam logic [ADDR_W-1:0] UPPER_BASE = 8'h10;
   localparam logic [ADDR_W-1:0] ENABLE_OFS = 8'h18;
   localparam logic [ADDR_W-1:0] HIZ_OFS = 8'h19;
   localparam logic [ADDR_W-1:0] RANGE_BASE = 8'h20;
   localparam logic [ADDR_W-1:0] APPLIED_BASE = 8'h28;
   // Reset values; inverted limits keep buffers off until the load
   localparam logic [CODE_W-1:0] CODE_RST = 8'h7f;
   localparam logic [CODE_W-1:0] LOWER_RST = 8'hff;
   localparam logic [CODE_W-1:0] UPPER_RST = 8'h00;
   localparam logic [RANGE_W-1:0] RANGE_RST = 2'h0;
   // Buffer tracking time before the output stage turns on
   localparam int unsigned CLK_PERIOD_NS = 100;
   localparam int unsigned TRACK_TIME_NS = 2000;
   localparam int unsigned TRACK_CYCLES = (TRACK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TRACK_CNT_W = 5;
   typedef enum logic [2:0] {
      CH_OFF = 3'b001,
      CH_TRACK = 3'b010,
      CH_DRIVE = 3'b100
   } ch_state_e;
endpackage
